// [inc/pus_pkg.sv]
// Package for the power-up and initialization sequencer.
// Assumes a single 100 MHz clock domain and a synchronous active-low reset.
`default_nettype none

package pus_pkg;

    // ---------------------------------------------------------------
    // Configuration store layout
    // ---------------------------------------------------------------
    localparam int unsigned CFG_WORDS      = 8;
    localparam int unsigned CFG_AW         = 3;
    localparam logic [2:0]  CFG_IDX_FREQ   = 3'h0;
    localparam logic [2:0]  CFG_IDX_VSET   = 3'h1;
    localparam logic [2:0]  CFG_IDX_I2CA   = 3'h2;
    localparam logic [2:0]  CFG_IDX_PMBA   = 3'h3;
    localparam logic [2:0]  CFG_IDX_ONOFF  = 3'h4;

    // ---------------------------------------------------------------
    // Switching frequency limits in kHz and output setpoint floor in mV
    // ---------------------------------------------------------------
    localparam logic [15:0] FREQ_MIN_KHZ   = 16'h00A6;
    localparam logic [15:0] FREQ_MAX_KHZ   = 16'h05DC;
    localparam logic [15:0] VSET_MIN_MV    = 16'h01F4;

    // ---------------------------------------------------------------
    // Address sampling
    // ---------------------------------------------------------------
    localparam int unsigned ADC_W          = 10;
    localparam logic [9:0]  ADC_FLOAT_MIN  = 10'h3F0;
    localparam logic [6:0]  ADDR_OFF       = 7'h00;

    // ---------------------------------------------------------------
    // Enable option field in the on/off word
    // ---------------------------------------------------------------
    localparam int unsigned ONOFF_SW_BIT   = 0;
    localparam int unsigned ONOFF_RUN_BIT  = 1;
    localparam logic [15:0] ONOFF_RST      = 16'h0000;

    // ---------------------------------------------------------------
    // Oscillator settle time in ns and cycles at 10 ns
    // ---------------------------------------------------------------
    localparam int unsigned CLK_NS         = 10;
    localparam int unsigned SETTLE_NS      = 100;
    localparam int unsigned SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        PUS_RESET,
        PUS_LOAD,
        PUS_ADDR,
        PUS_IDLE,
        PUS_RUN
    } pus_state_t;

endpackage

`default_nettype wire

// [hw/pus_sequencer.sv]
// Power-up sequencer: holds reset, loads configuration, reads address, gates conversion.
// Assumes pins are asynchronous and the store answers one word per cycle.
`timescale 1ns/10ps
`default_nettype none

module pus_sequencer
    import pus_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Supply and oscillator monitors
    input  wire logic              supply_ok,
    input  wire logic              core_logic_rail_ok,
    input  wire logic              osc_stable,
    // Comparator and pin inputs
    input  wire logic              enable_forced_ccm_pin,
    input  wire logic              bus_uv_ok,
    // Nonvolatile configuration store read port
    output logic [CFG_AW-1:0]      nvm_addr,
    input  wire logic [15:0]       nvm_data,
    // Address-select converter
    output logic                   adc_start,
    input  wire logic              adc_done,
    input  wire logic [ADC_W-1:0]  adc_value,
    // Management bus configuration writes
    input  wire logic              cfg_wr,
    input  wire logic [CFG_AW-1:0] cfg_wr_idx,
    input  wire logic [15:0]       cfg_wr_data,
    input  wire logic              ext_vset_sel,
    input  wire logic [15:0]       ext_vset_mv,
    // Status and results
    output logic                   int_reset_n,
    output logic                   load_done,
    output logic                   addr_done,
    output logic                   analog_mode,
    output logic [6:0]             i2c_addr,
    output logic [6:0]             pmb_addr,
    output logic                   i2c_en,
    output logic                   pmb_en,
    output logic [15:0]            freq_khz,
    output logic [15:0]            vset_mv,
    output logic                   conv_en
);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [2:0] s_sup_q, s_core_q, s_osc_q, s_en_q, s_uv_q;
    logic       sup_q, core_q, osc_q, en_q, uv_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_sup_q  <= 3'h0;
            s_core_q <= 3'h0;
            s_osc_q  <= 3'h0;
            s_en_q   <= 3'h0;
            s_uv_q   <= 3'h0;
        end else begin
            s_sup_q  <= {s_sup_q[1:0], supply_ok};
            s_core_q <= {s_core_q[1:0], core_logic_rail_ok};
            s_osc_q  <= {s_osc_q[1:0], osc_stable};
            s_en_q   <= {s_en_q[1:0], enable_forced_ccm_pin};
            s_uv_q   <= {s_uv_q[1:0], bus_uv_ok};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sup_q  <= 1'b0;
            core_q <= 1'b0;
            osc_q  <= 1'b0;
            en_q   <= 1'b0;
            uv_q   <= 1'b0;
        end else begin
            if (s_sup_q[1] == s_sup_q[2])   sup_q  <= s_sup_q[2];
            if (s_core_q[1] == s_core_q[2]) core_q <= s_core_q[2];
            if (s_osc_q[1] == s_osc_q[2])   osc_q  <= s_osc_q[2];
            if (s_en_q[1] == s_en_q[2])     en_q   <= s_en_q[2];
            if (s_uv_q[1] == s_uv_q[2])     uv_q   <= s_uv_q[2];
        end
    end

    // ---------------------------------------------------------------
    // Sequencer state
    // ---------------------------------------------------------------
    pus_state_t            state_q;
    logic [CFG_AW:0]       ld_cnt_q;
    logic [7:0]            settle_q;
    logic [15:0]           cfg_q [CFG_WORDS];
    logic [3:0]            addr_off_q;
    logic                  rails_ok;
    logic                  cond_ok;
    logic                  sw_mode;

    assign rails_ok = sup_q && core_q && osc_q;
    assign sw_mode  = cfg_q[CFG_IDX_ONOFF][ONOFF_SW_BIT] && !analog_mode;
    // Software options replace the pin and threshold terms when selected outside analog mode.
    assign cond_ok  = load_done && addr_done &&
                      (sw_mode ? cfg_q[CFG_IDX_ONOFF][ONOFF_RUN_BIT]
                               : (en_q && uv_q));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q  <= PUS_RESET;
            settle_q <= 8'h00;
            ld_cnt_q <= '0;
        end else begin
            case (state_q)
                PUS_RESET: begin
                    if (!rails_ok) begin
                        settle_q <= 8'h00;
                    end else if (settle_q == 8'(SETTLE_CYC)) begin
                        state_q  <= PUS_LOAD;
                        ld_cnt_q <= '0;
                    end else begin
                        settle_q <= settle_q + 8'h01;
                    end
                end
                PUS_LOAD: begin
                    ld_cnt_q <= ld_cnt_q + (CFG_AW+1)'(1);
                    if (ld_cnt_q == (CFG_AW+1)'(CFG_WORDS)) begin
                        state_q <= PUS_ADDR;
                    end
                end
                PUS_ADDR: begin
                    if (adc_done) state_q <= PUS_IDLE;
                end
                PUS_IDLE: begin
                    if (cond_ok) state_q <= PUS_RUN;
                end
                PUS_RUN: begin
                    if (!cond_ok) state_q <= PUS_IDLE;
                end
                default: state_q <= PUS_RESET;
            endcase
            if (!rails_ok) begin
                state_q  <= PUS_RESET;
                settle_q <= 8'h00;
            end
        end
    end

    assign int_reset_n = (state_q != PUS_RESET);
    assign nvm_addr    = ld_cnt_q[CFG_AW-1:0];
    assign adc_start   = (state_q == PUS_ADDR);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            load_done <= 1'b0;
            addr_done <= 1'b0;
        end else begin
            load_done <= (state_q == PUS_IDLE) || (state_q == PUS_RUN) ||
                         (state_q == PUS_ADDR);
            addr_done <= (state_q == PUS_IDLE) || (state_q == PUS_RUN);
        end
    end

    // ---------------------------------------------------------------
    // Working registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < CFG_WORDS; i++) cfg_q[i] <= 16'h0000;
        end else if (state_q == PUS_LOAD && !ld_cnt_q[CFG_AW]) begin
            // The store answers in the same cycle, so word n lands while the counter shows n.
            cfg_q[ld_cnt_q[CFG_AW-1:0]] <= nvm_data;
        end else if (cfg_wr && load_done && !analog_mode &&
                     (i2c_en || pmb_en)) begin
            cfg_q[cfg_wr_idx] <= cfg_wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            addr_off_q  <= 4'h0;
            analog_mode <= 1'b0;
        end else if (state_q == PUS_ADDR && adc_done) begin
            analog_mode <= (adc_value >= ADC_FLOAT_MIN);
            addr_off_q  <= adc_value[ADC_W-1:ADC_W-4];
        end
    end

    // ---------------------------------------------------------------
    // Derived settings
    // ---------------------------------------------------------------
    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            i2c_addr <= ADDR_OFF;
            pmb_addr <= ADDR_OFF;
            freq_khz <= FREQ_MIN_KHZ;
            vset_mv  <= VSET_MIN_MV;
            conv_en  <= 1'b0;
        end else begin
            i2c_addr <= cfg_q[CFG_IDX_I2CA][6:0] + {3'h0, addr_off_q};
            pmb_addr <= cfg_q[CFG_IDX_PMBA][6:0] + {3'h0, addr_off_q};
            freq_khz <= clamp16(cfg_q[CFG_IDX_FREQ], FREQ_MIN_KHZ,
                                FREQ_MAX_KHZ);
            vset_mv  <= clamp16(ext_vset_sel ? ext_vset_mv
                                : cfg_q[CFG_IDX_VSET], VSET_MIN_MV, 16'hFFFF);
            conv_en  <= (state_q == PUS_RUN) && cond_ok;
        end
    end

    assign i2c_en = !analog_mode && (cfg_q[CFG_IDX_I2CA][6:0] != ADDR_OFF);
    assign pmb_en = !analog_mode && (cfg_q[CFG_IDX_PMBA][6:0] != ADDR_OFF);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence rails_lost_s;
        !rails_ok;
    endsequence

    hold_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
        rails_lost_s |=> !int_reset_n) else $error("reset released early");
    load_first_a: assert property (@(posedge clk) disable iff (!reset_n)
        conv_en |-> load_done) else $error("conversion before load");
    wr_accept_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cfg_wr && load_done && pmb_en && state_q != PUS_LOAD && cfg_wr_idx == CFG_IDX_FREQ)
        |=> cfg_q[CFG_IDX_FREQ] == $past(cfg_wr_data)) else $error("write lost");
    def_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (conv_en && $past(!sw_mode)) |-> $past(en_q && uv_q && addr_done))
        else $error("enable without conditions");
    sw_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (conv_en && $past(sw_mode)) |-> $past(cfg_q[CFG_IDX_ONOFF][ONOFF_RUN_BIT]))
        else $error("software enable ignored");
    freq_range_a: assert property (@(posedge clk) disable iff (!reset_n)
        freq_khz >= FREQ_MIN_KHZ && freq_khz <= FREQ_MAX_KHZ) else $error("freq range");
    vset_floor_a: assert property (@(posedge clk) disable iff (!reset_n)
        vset_mv >= VSET_MIN_MV) else $error("setpoint floor");
    analog_bus_a: assert property (@(posedge clk) disable iff (!reset_n)
        analog_mode |-> !i2c_en && !pmb_en) else $error("bus on in analog");
    analog_wr_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cfg_wr && analog_mode && state_q != PUS_LOAD)
        |=> cfg_q[$past(cfg_wr_idx)] == $past(cfg_q[cfg_wr_idx]))
        else $error("write taken in analog mode");
    stop_lost_a: assert property (@(posedge clk) disable iff (!reset_n)
        (conv_en && !cond_ok) |=> !conv_en) else $error("no stop");

endmodule

`default_nettype wire

// [tb/pus_far_model.sv]
// Far-side model: the configuration store and the address-select converter.
// Assumes the sequencer reads the store combinationally and holds adc_start as a level.
`timescale 1ns/10ps
`default_nettype none

module pus_far_model
    import pus_pkg::*;
#(
    parameter int unsigned ADC_LAT = 5
)(
    // Clock
    input  wire logic              clk,
    // Store read port
    input  wire logic [CFG_AW-1:0] nvm_addr,
    output logic [15:0]            nvm_data,
    // Address-select converter
    input  wire logic              adc_start,
    input  wire logic [ADC_W-1:0]  adc_code,
    output logic                   adc_done,
    output logic [ADC_W-1:0]       adc_value
);
    logic [15:0] store [CFG_WORDS];
    int          cnt;

    initial begin
        store = '{16'h0258, 16'h0384, 16'h0010, 16'h0020, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        cnt = 0;
        adc_done = 1'b0;
    end

    assign nvm_data = store[nvm_addr];
    // The code is valid only with the done pulse; at other times the bus shows its inverse.
    assign adc_value = adc_done ? adc_code : ~adc_code;

    // One done pulse for each rise of adc_start, after a fixed conversion time.
    always @(posedge clk) begin
        adc_done <= 1'b0;
        if (!adc_start) begin
            cnt <= 0;
        end else if (cnt <= ADC_LAT) begin
            cnt <= cnt + 1;
            adc_done <= (cnt == ADC_LAT);
        end
    end
endmodule

`default_nettype wire

// [tb/tb_pus_sequencer.sv]
// Testbench for the power-up sequencer: rails, load, address, gating and bus writes.
// Assumes the far-side model answers the store and the address converter.
`timescale 1ns/10ps
`default_nettype none

module tb_pus_sequencer
    import pus_pkg::*;
;
    logic              clk, reset_n, supply_ok, core_logic_rail_ok, osc_stable;
    logic              enable_forced_ccm_pin, bus_uv_ok, cfg_wr, ext_vset_sel;
    logic [CFG_AW-1:0] cfg_wr_idx, nvm_addr;
    logic [15:0]       cfg_wr_data, ext_vset_mv, nvm_data, freq_khz, vset_mv;
    logic [ADC_W-1:0]  adc_code, adc_value;
    logic              adc_start, adc_done, int_reset_n, load_done, addr_done, analog_mode;
    logic              i2c_en, pmb_en, conv_en;
    logic [6:0]        i2c_addr, pmb_addr;
    logic [2:0]        mon;
    int                n_mismatch = 0;
    int                total_checks = 0;

    assign mon = {int_reset_n, addr_done, conv_en};

    always #5 clk = ~clk;

    pus_sequencer i_dut (
        .clk(clk), .reset_n(reset_n), .supply_ok(supply_ok),
        .core_logic_rail_ok(core_logic_rail_ok), .osc_stable(osc_stable),
        .enable_forced_ccm_pin(enable_forced_ccm_pin), .bus_uv_ok(bus_uv_ok),
        .nvm_addr(nvm_addr), .nvm_data(nvm_data), .adc_start(adc_start),
        .adc_done(adc_done), .adc_value(adc_value), .cfg_wr(cfg_wr),
        .cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data), .ext_vset_sel(ext_vset_sel),
        .ext_vset_mv(ext_vset_mv), .int_reset_n(int_reset_n), .load_done(load_done),
        .addr_done(addr_done), .analog_mode(analog_mode), .i2c_addr(i2c_addr),
        .pmb_addr(pmb_addr), .i2c_en(i2c_en), .pmb_en(pmb_en), .freq_khz(freq_khz),
        .vset_mv(vset_mv), .conv_en(conv_en)
    );

    pus_far_model i_far (
        .clk(clk), .nvm_addr(nvm_addr), .nvm_data(nvm_data), .adc_start(adc_start),
        .adc_code(adc_code), .adc_done(adc_done), .adc_value(adc_value)
    );

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    // Waits a bounded number of cycles for one monitored status bit to reach a level.
    task automatic wait_mon(input int b, input logic v, input int lim);
        for (int i = 0; i < lim && mon[b] !== v; i++) tick(1);
        chk(mon[b] === v, "status bit did not reach the expected level in time");
        if (mon[b] !== v) conclude();
    endtask

    task automatic rails(input logic [2:0] v);
        @(posedge clk);
        {supply_ok, core_logic_rail_ok, osc_stable} <= v;
    endtask

    task automatic cfg(input logic [2:0] idx, input logic [15:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_wr_idx <= idx;
        cfg_wr_data <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
        tick(4);
    endtask

    task automatic t_por();
        for (int k = 0; k < 3; k++) begin
            rails(3'b111 ^ (3'b001 << k));
            tick(25);
            chk(int_reset_n === 1'b0, "internal reset released with a monitor low");
            chk(conv_en === 1'b0, "conversion on before load");
        end
        $display("test por done");
    endtask

    task automatic t_load();
        rails(3'b111);
        adc_code <= 10'h140;
        wait_mon(2, 1'b1, 40);
        wait_mon(1, 1'b1, 60);
        chk(load_done === 1'b1, "load not flagged");
        chk(freq_khz === 16'h0258 && vset_mv === 16'h0384, "stored words not loaded");
        chk(i2c_addr === 7'h15 && pmb_addr === 7'h25, "offset not added");
        chk({analog_mode, i2c_en, pmb_en} === 3'b011, "digital mode wrong");
        $display("test load done");
    endtask

    task automatic t_gate();
        @(posedge clk);
        enable_forced_ccm_pin <= 1'b0;
        wait_mon(0, 1'b0, 10);
        tick(10);
        chk(conv_en === 1'b0, "conversion on with enable low");
        @(posedge clk);
        enable_forced_ccm_pin <= 1'b1;
        wait_mon(0, 1'b1, 10);
        @(posedge clk);
        bus_uv_ok <= 1'b0;
        wait_mon(0, 1'b0, 10);
        tick(10);
        chk(conv_en === 1'b0, "restart without bus level");
        @(posedge clk);
        bus_uv_ok <= 1'b1;
        wait_mon(0, 1'b1, 10);
        @(posedge clk);
        enable_forced_ccm_pin <= 1'b0;
        wait_mon(0, 1'b0, 10);
        $display("test gate done");
    endtask

    task automatic t_cfg();
        cfg(CFG_IDX_FREQ, 16'h0064);
        chk(freq_khz === FREQ_MIN_KHZ, "low frequency not clamped");
        cfg(CFG_IDX_FREQ, 16'h0800);
        chk(freq_khz === FREQ_MAX_KHZ, "high frequency not clamped");
        cfg(CFG_IDX_FREQ, 16'h01F4);
        chk(freq_khz === 16'h01F4, "frequency write lost");
        cfg(CFG_IDX_VSET, 16'h0064);
        chk(vset_mv === VSET_MIN_MV, "setpoint floor missing");
        @(posedge clk);
        ext_vset_sel <= 1'b1;
        ext_vset_mv <= 16'h0320;
        tick(4);
        chk(vset_mv === 16'h0320, "resistor setpoint not used");
        @(posedge clk);
        ext_vset_sel <= 1'b0;
        cfg(CFG_IDX_ONOFF, 16'h0003);
        wait_mon(0, 1'b1, 10);
        cfg(CFG_IDX_ONOFF, 16'h0001);
        wait_mon(0, 1'b0, 10);
        cfg(CFG_IDX_ONOFF, 16'h0000);
        cfg(CFG_IDX_I2CA, 16'h0000);
        chk({i2c_en, pmb_en} === 2'b01, "zero base left bus on");
        cfg(CFG_IDX_PMBA, 16'h0000);
        cfg(CFG_IDX_FREQ, 16'h0300);
        chk(freq_khz === 16'h01F4 && pmb_en === 1'b0, "write taken with buses off");
        $display("test cfg done");
    endtask

    task automatic t_analog();
        rails(3'b000);
        tick(8);
        chk(int_reset_n === 1'b0 && conv_en === 1'b0, "rail loss not seen");
        rails(3'b111);
        adc_code <= ADC_FLOAT_MIN;
        wait_mon(1, 1'b1, 100);
        chk({analog_mode, i2c_en, pmb_en} === 3'b100, "floating pin not analog");
        chk(freq_khz === 16'h0258, "store not reloaded");
        chk(i2c_addr === 7'h1F, "top offset not added to reloaded base");
        cfg(CFG_IDX_FREQ, 16'h0300);
        chk(freq_khz === 16'h0258, "write taken in analog mode");
        $display("test analog done");
    endtask

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {supply_ok, core_logic_rail_ok, osc_stable} = 3'b000;
        {enable_forced_ccm_pin, bus_uv_ok, cfg_wr, ext_vset_sel} = 4'b1100;
        cfg_wr_idx = 3'h0;
        cfg_wr_data = 16'h0000;
        ext_vset_mv = 16'h0000;
        adc_code = 10'h000;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_por();
        t_load();
        t_gate();
        t_cfg();
        t_analog();
        conclude();
    end
endmodule

`default_nettype wire
